// ==== core/dmau_pkg.sv ====
// dmau_pkg: constants and types shared by the data memory address unit
// assumes a byte-addressed data ram of 17-bit words (16 data + flag bit)
package dmau_pkg;

    // ---------------------------------------------------------------
    // widths and sizes
    // ---------------------------------------------------------------
    localparam int unsigned DMAU_AW        = 16;  // byte address width
    localparam int unsigned DMAU_WA        = 15;  // word index width
    localparam int unsigned DMAU_SLW       = 8;   // string length reg width
    localparam logic [DMAU_WA-1:0] DMAU_FLAG_MAX = 15'h027f; // last flag
    localparam logic [DMAU_SLW-1:0] DMAU_SLEN_RST = 8'h00;   // after reset
    localparam logic [8:0] DMAU_SLEN_BIAS = 9'h002; // stored len = n - 2
    localparam logic [DMAU_AW-1:0] DMAU_STEP_BYTE = 16'h0001;
    localparam logic [DMAU_AW-1:0] DMAU_STEP_WORD = 16'h0002;
    localparam logic [DMAU_AW-1:0] DMAU_ADDR_RST  = 16'h0000;

    // access modes
    typedef enum logic [2:0] {
        DMAU_M_BYTE,
        DMAU_M_BSTR,
        DMAU_M_WORD,
        DMAU_M_WSTR,
        DMAU_M_FLAG
    } dmau_mode_t;

    // flag operations
    typedef enum logic [1:0] {
        DMAU_F_READ,
        DMAU_F_SET,
        DMAU_F_CLR,
        DMAU_F_WRITE
    } dmau_fop_t;

endpackage

// ==== core/dmau_ram_if.sv ====
// dmau_ram_if: one ram access beat between the sequencer and the port
// assumes a single core clock on both ends
`timescale 1ns/10ps
`default_nettype none
interface dmau_ram_if;
    import dmau_pkg::*;
    logic              req;      // beat valid
    logic              we;       // write beat
    logic              word;     // both bytes of a word
    logic              flag;     // flag bit only
    logic [DMAU_AW-1:0] addr;    // byte address
    logic [15:0]       wdata;    // write data
    logic              wflag;    // flag write value
    modport seq  (output req, we, word, flag, addr, wdata, wflag);
    modport port (input  req, we, word, flag, addr, wdata, wflag);
endinterface
`default_nettype wire

// ==== core/dmau_ram_port.sv ====
// dmau_ram_port: turns one beat into ram pin signals
// assumes ram answers reads in the same cycle (combinational read data)
`timescale 1ns/10ps
`default_nettype none
module dmau_ram_port
    import dmau_pkg::*;
(
    dmau_ram_if.port          bt,        // beat from sequencer
    output logic [DMAU_AW-1:0] o_a0,     // even/first byte address
    output logic [DMAU_AW-1:0] o_a1,     // odd byte address of word
    output logic [1:0]        o_ben,     // byte lane enables
    output logic              o_fen,     // flag bit access
    output logic              o_we,      // write strobe
    output logic [7:0]        o_wd0,     // byte to a0
    output logic [7:0]        o_wd1,     // byte to a1
    output logic              o_wfl      // flag write value
);
    // ---------------------------------------------------------------
    // address generation
    // ---------------------------------------------------------------
    always_comb begin
        o_a0  = bt.addr;
        o_a1  = bt.addr;
        o_ben = 2'h0;
        o_fen = 1'b0;
        o_wd0 = bt.wdata[7:0];
        o_wd1 = 8'h00;
        if (bt.req && bt.flag) begin
            // flag uses the word's even byte address
            o_a0  = {bt.addr[DMAU_AW-1:1], 1'b0}; // RULE11
            o_a1  = o_a0;
            o_fen = 1'b1; // RULE15
        end else if (bt.req && bt.word) begin
            o_a0  = {bt.addr[DMAU_AW-1:1], 1'b0}; // RULE7
            o_a1  = {bt.addr[DMAU_AW-1:1], 1'b1}; // RULE8
            o_ben = 2'h3; // RULE8
            o_wd0 = bt.wdata[15:8]; // RULE9
            o_wd1 = bt.wdata[7:0]; // RULE9
        end else if (bt.req) begin
            o_ben = 2'h1; // RULE1
        end
    end
    assign o_we  = bt.req & bt.we;
    assign o_wfl = bt.wflag;
endmodule // dmau_ram_port
`default_nettype wire

// ==== core/dmau_core.sv ====
// dmau_core: data memory address unit, top level
// assumes execution logic holds a request until o_done; ram read is
// combinational on the address pins
`timescale 1ns/10ps
`default_nettype none
// How it works
// RULE1: data ram reached by byte address only
// RULE2: byte read zero-fills upper eight bits
// RULE3: length register holds count minus two
// RULE4: byte string starts at any parity
// RULE5: byte string steps one byte upward
// RULE6: pointer moves one per byte, two per word
// RULE7: word access clears address lsb
// RULE8: word moves both bytes in one cycle
// RULE9: even byte is msb, odd byte lsb
// RULE10: word string aligned, steps words upward
// RULE11: flag index word-linear, bit 17 only
// RULE12: every word read copies flag to tag
// RULE13: string read tag from last word
// RULE14: flags set, cleared, written by logic
// RULE15: flag access no string, no post-modify
// RULE16: even/odd byte pair share one flag
// RULE17: byte read also updates tag
// RULE18: pointer ends advanced by bytes moved
module dmau_core
    import dmau_pkg::*;
(
    input  wire logic              i_sys_clk,   // core clock
    input  wire logic              i_rst,       // sync reset, high
    input  wire logic              i_slen_we,   // load length register
    input  wire logic [DMAU_SLW-1:0] i_slen,    // count minus two
    input  wire logic              i_req,       // start access
    input  wire dmau_mode_t        i_mode,      // access kind
    input  wire logic              i_we,        // write access
    input  wire dmau_fop_t         i_fop,       // flag operation
    input  wire logic              i_fval,      // flag value for write
    input  wire logic [DMAU_AW-1:0] i_addr,     // byte addr or flag index
    input  wire logic              i_post_en,   // post-modify pointer
    input  wire logic              i_post_dec,  // 1 = decrement
    input  wire logic [15:0]       i_wdata,     // write data per element
    input  wire logic [7:0]        i_rd0,       // ram byte at a0
    input  wire logic [7:0]        i_rd1,       // ram byte at a1
    input  wire logic              i_rfl,       // ram flag of word
    output logic [DMAU_AW-1:0]     o_ram_a0,    // ram byte address 0
    output logic [DMAU_AW-1:0]     o_ram_a1,    // ram byte address 1
    output logic [1:0]             o_ram_ben,   // ram byte enables
    output logic                   o_ram_fen,   // ram flag access
    output logic                   o_ram_we,    // ram write
    output logic [7:0]             o_ram_wd0,   // write byte 0
    output logic [7:0]             o_ram_wd1,   // write byte 1
    output logic                   o_ram_wfl,   // flag write value
    output logic                   o_busy,      // access in progress
    output logic                   o_elem,      // element strobe
    output logic [15:0]            o_rdata,     // element read data
    output logic                   o_done,      // access finished
    output logic [DMAU_AW-1:0]     o_ptr_new,   // post-modified pointer
    output logic                   o_tag,       // status tag bit
    output logic [DMAU_SLW-1:0]    o_slen       // length register
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {DMAU_S_IDLE, DMAU_S_RUN, DMAU_S_END}
        dmau_st_t;
    dmau_st_t          st_r, st_nxt;          // sequencer state
    logic [DMAU_AW-1:0] addr_r, addr_nxt;     // current byte address
    logic [DMAU_AW-1:0] ptr_r, ptr_nxt;       // pointer result
    logic [8:0]        cnt_r, cnt_nxt;        // elements remaining
    dmau_mode_t        mode_r, mode_nxt;      // latched mode
    logic              we_r, we_nxt;          // latched write
    dmau_fop_t         fop_r, fop_nxt;        // latched flag op
    logic              fval_r, fval_nxt;      // latched flag value
    logic              post_r, post_nxt;      // latched post enable
    logic              dec_r, dec_nxt;        // latched direction
    logic [DMAU_SLW-1:0] slen_r, slen_nxt;    // string length register
    logic              tag_r, tag_nxt;        // status tag
    logic [15:0]       rd_r, rd_nxt;          // read data
    logic              elem_r, elem_nxt;      // element strobe
    logic              done_r, done_nxt;      // done strobe
    logic              isword, isstr, isflag; // mode decode
    logic [DMAU_AW-1:0] step;                 // per element step
    logic              flag_ok;               // flag index in range

    dmau_ram_if bt ();                        // beat to port

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    always_comb begin
        isword = (mode_r == DMAU_M_WORD) || (mode_r == DMAU_M_WSTR);
        isstr  = (mode_r == DMAU_M_BSTR) || (mode_r == DMAU_M_WSTR);
        isflag = (mode_r == DMAU_M_FLAG);
        step   = isword ? DMAU_STEP_WORD : DMAU_STEP_BYTE; // RULE6
        flag_ok = (addr_r <= {1'b0, DMAU_FLAG_MAX}); // RULE11
    end

    // beat drive
    always_comb begin
        bt.req   = (st_r == DMAU_S_RUN) && (!isflag || flag_ok);
        // flag beats write only for set, clear and write ops
        bt.we    = isflag ? (fop_r != DMAU_F_READ) : we_r;
        bt.word  = isword;
        bt.flag  = isflag;
        bt.addr  = isflag ? {addr_r[DMAU_AW-2:0], 1'b0} : addr_r;
        bt.wdata = i_wdata;
        bt.wflag = (fop_r == DMAU_F_SET) ? 1'b1 :            // RULE14
                   (fop_r == DMAU_F_CLR) ? 1'b0 : fval_r;    // RULE14
    end

    dmau_ram_port u_port (
        .bt    (bt),
        .o_a0  (o_ram_a0),
        .o_a1  (o_ram_a1),
        .o_ben (o_ram_ben),
        .o_fen (o_ram_fen),
        .o_we  (o_ram_we),
        .o_wd0 (o_ram_wd0),
        .o_wd1 (o_ram_wd1),
        .o_wfl (o_ram_wfl)
    );

    // ---------------------------------------------------------------
    // sequencer next state
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt   = st_r;
        addr_nxt = addr_r;
        ptr_nxt  = ptr_r;
        cnt_nxt  = cnt_r;
        mode_nxt = mode_r;
        we_nxt   = we_r;
        fop_nxt  = fop_r;
        fval_nxt = fval_r;
        post_nxt = post_r;
        dec_nxt  = dec_r;
        slen_nxt = slen_r;
        tag_nxt  = tag_r;
        rd_nxt   = rd_r;
        elem_nxt = 1'b0;
        done_nxt = 1'b0;
        if (i_slen_we && st_r == DMAU_S_IDLE) begin
            slen_nxt = i_slen; // RULE3
        end
        case (st_r)
            DMAU_S_IDLE: begin
                if (i_req) begin
                    st_nxt   = DMAU_S_RUN;
                    mode_nxt = i_mode;
                    we_nxt   = i_we;
                    fop_nxt  = i_fop;
                    fval_nxt = i_fval;
                    post_nxt = i_post_en && (i_mode != DMAU_M_FLAG); // RULE15
                    dec_nxt  = i_post_dec;
                    ptr_nxt  = i_addr;
                    // words align, byte strings keep parity
                    if (i_mode == DMAU_M_WORD || i_mode == DMAU_M_WSTR)
                        addr_nxt = {i_addr[DMAU_AW-1:1], 1'b0}; // RULE10
                    else
                        addr_nxt = i_addr; // RULE4
                    // strings run length + 2 elements, others one
                    if (i_mode == DMAU_M_BSTR || i_mode == DMAU_M_WSTR)
                        cnt_nxt = {1'b0, slen_r} + DMAU_SLEN_BIAS; // RULE3
                    else
                        cnt_nxt = 9'h001; // RULE15
                end
            end
            DMAU_S_RUN: begin
                elem_nxt = 1'b1;
                if (isflag ? (fop_r == DMAU_F_READ) : !we_r) begin
                    // byte: always take lane 0 (i_rd0), zero-fill top
                    if (isword)
                        rd_nxt = {i_rd0, i_rd1}; // RULE9
                    else if (!isflag)
                        rd_nxt = {8'h00, i_rd0}; // RULE2
                    // last read wins, odd/even bytes share flag
                    if (!isflag || fop_r == DMAU_F_READ)
                        tag_nxt = i_rfl; // RULE12 RULE13 RULE16 RULE17
                end
                if (isflag && fop_r == DMAU_F_READ && !flag_ok)
                    tag_nxt = 1'b0;
                if (isflag && fop_r != DMAU_F_READ)
                    tag_nxt = tag_r;
                addr_nxt = addr_r + step; // RULE5 RULE10
                if (post_r) begin
                    if (dec_r)
                        ptr_nxt = ptr_r - step; // RULE6
                    else
                        ptr_nxt = ptr_r + step; // RULE6 RULE18
                end
                cnt_nxt = cnt_r - 9'h001;
                if (cnt_r == 9'h001)
                    st_nxt = DMAU_S_END;
            end
            DMAU_S_END: begin
                done_nxt = 1'b1;
                st_nxt   = DMAU_S_IDLE;
            end
            default: st_nxt = DMAU_S_IDLE;
        endcase
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st_r   <= DMAU_S_IDLE;
            addr_r <= DMAU_ADDR_RST;
            ptr_r  <= DMAU_ADDR_RST;
            cnt_r  <= 9'h000;
            mode_r <= DMAU_M_BYTE;
            we_r   <= 1'b0;
            fop_r  <= DMAU_F_READ;
            fval_r <= 1'b0;
            post_r <= 1'b0;
            dec_r  <= 1'b0;
            slen_r <= DMAU_SLEN_RST;
            tag_r  <= 1'b0;
            rd_r   <= 16'h0000;
            elem_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            addr_r <= addr_nxt;
            ptr_r  <= ptr_nxt;
            cnt_r  <= cnt_nxt;
            mode_r <= mode_nxt;
            we_r   <= we_nxt;
            fop_r  <= fop_nxt;
            fval_r <= fval_nxt;
            post_r <= post_nxt;
            dec_r  <= dec_nxt;
            slen_r <= slen_nxt;
            tag_r  <= tag_nxt;
            rd_r   <= rd_nxt;
            elem_r <= elem_nxt;
            done_r <= done_nxt;
        end
    end

    // outputs
    assign o_busy    = (st_r != DMAU_S_IDLE);
    assign o_elem    = elem_r;
    assign o_rdata   = rd_r;
    assign o_done    = done_r;
    assign o_ptr_new = ptr_r;
    assign o_tag     = tag_r;
    assign o_slen    = slen_r;
endmodule // dmau_core
`default_nettype wire

// ==== testbench/dmau_core_props.sv ====
// dmau_core_props: port-level checks for the data memory address unit
// assumes one clock, sync active-high reset, bound into dmau_core
`timescale 1ns/10ps
`default_nettype none
module dmau_core_props
    import dmau_pkg::*;
(
    input wire logic               i_sys_clk, i_rst, i_req, i_we,
    input wire logic               i_post_en, i_post_dec, i_rfl,
    input wire dmau_mode_t         i_mode,
    input wire logic [DMAU_AW-1:0] i_addr, o_ram_a0, o_ram_a1, o_ptr_new,
    input wire logic [7:0]         i_rd0, i_rd1,
    input wire logic [1:0]         o_ram_ben,
    input wire logic               o_ram_fen, o_ram_we, o_busy, o_elem,
    input wire logic               o_done, o_tag,
    input wire logic [15:0]        o_rdata
);
    // ------------------------------------------------------------
    // request capture
    // ------------------------------------------------------------
    dmau_mode_t         mode_r;  // mode of access in flight
    logic               wr_r;    // write access in flight
    logic               inc_r;   // post-increment asked for
    logic [DMAU_AW-1:0] addr_r;  // address as taken
    // latch the request at the edge that takes it
    always_ff @(posedge i_sys_clk) begin
        if (!o_busy && i_req) begin
            mode_r <= i_mode;
            wr_r   <= i_we;
            inc_r  <= i_post_en && !i_post_dec;
            addr_r <= i_addr;
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_word_pair: assert property (
        o_ram_ben == 2'b11 |-> !o_ram_a0[0] && o_ram_a1 == o_ram_a0 + 16'h1)
        else $error("word beat not an aligned byte pair");
    chk_byte_lane: assert property (
        o_ram_ben == 2'b01 |-> o_ram_a1 == o_ram_a0 && !o_ram_fen)
        else $error("byte beat addresses differ");
    chk_byte_zero: assert property (
        o_elem && !wr_r && (mode_r == DMAU_M_BYTE || mode_r == DMAU_M_BSTR)
        |-> o_rdata[15:8] == 8'h00) else $error("byte read not zero filled");
    chk_word_order: assert property (
        o_elem && !wr_r && mode_r == DMAU_M_WORD
        |-> o_rdata == {$past(i_rd0), $past(i_rd1)})
        else $error("word bytes in wrong order");
    chk_tag_copy: assert property (
        o_elem && !wr_r && mode_r != DMAU_M_FLAG |-> o_tag == $past(i_rfl))
        else $error("tag not taken from beat flag");
    chk_flag_tag: assert property (
        o_ram_fen && !o_ram_we |=> o_tag == $past(i_rfl))
        else $error("flag read not copied to tag");
    chk_bstr_step: assert property (
        o_ram_ben == 2'b01 && $past(o_ram_ben) == 2'b01
        && mode_r == DMAU_M_BSTR |-> o_ram_a0 == $past(o_ram_a0) + 16'h1)
        else $error("byte string does not step by one");
    chk_wstr_step: assert property (
        o_ram_ben == 2'b11 && $past(o_ram_ben) == 2'b11
        && mode_r == DMAU_M_WSTR |-> o_ram_a0 == $past(o_ram_a0) + 16'h2)
        else $error("word string does not step by two");
    chk_flag_bit: assert property (
        o_ram_fen |-> o_ram_ben == 2'b00 && !o_ram_a0[0]
        && o_ram_a0 <= 16'h04fe) else $error("flag beat malformed");
    chk_ptr_byte: assert property (
        o_done && inc_r && mode_r == DMAU_M_BYTE |-> o_ptr_new == addr_r + 16'h1)
        else $error("byte pointer not advanced by one");
    chk_ptr_word: assert property (
        o_done && inc_r && mode_r == DMAU_M_WORD |-> o_ptr_new == addr_r + 16'h2)
        else $error("word pointer not advanced by two");
    cover property (o_elem && mode_r == DMAU_M_BSTR);
    cover property (o_elem && mode_r == DMAU_M_WSTR);
    cover property (o_ram_fen && o_ram_we);
endmodule // dmau_core_props
bind dmau_core dmau_core_props dmau_core_props_i (.*);
`default_nettype wire

// ==== testbench/dmau_ram_model.sv ====
// dmau_ram_model: byte-addressed data ram of 640 words with flag bits
// assumes combinational read on the address pins, writes at the edge
`timescale 1ns/10ps
`default_nettype none
module dmau_ram_model (
    input  wire logic        i_sys_clk,  // core clock
    input  wire logic [15:0] i_a0,       // even or single byte address
    input  wire logic [15:0] i_a1,       // odd byte of a word
    input  wire logic [1:0]  i_ben,      // byte lanes
    input  wire logic        i_fen,      // flag access
    input  wire logic        i_we,       // write strobe
    input  wire logic [7:0]  i_wd0,      // byte to a0
    input  wire logic [7:0]  i_wd1,      // byte to a1
    input  wire logic        i_wfl,      // flag write value
    output logic      [7:0]  o_rd0,      // byte at a0
    output logic      [7:0]  o_rd1,      // byte at a1
    output logic             o_rfl       // flag of word holding a0
);
    logic [7:0] mem [0:1279];  // byte store
    logic       flg [0:639];   // one flag per even/odd pair
    logic       act;           // some lane selected
    // unselected reads show inverted data, never a held value
    assign act   = (i_ben != 2'b00) || i_fen;
    assign o_rd0 = act ? mem[i_a0] : ~mem[i_a0];
    assign o_rd1 = act ? mem[i_a1] : ~mem[i_a1];
    assign o_rfl = act ? flg[i_a0[10:1]] : ~flg[i_a0[10:1]];
    // writes land at the clock edge
    always @(posedge i_sys_clk) begin
        if (i_we && i_fen) flg[i_a0[10:1]] <= i_wfl;
        if (i_we && i_ben[0]) mem[i_a0] <= i_wd0;
        if (i_we && i_ben[1]) mem[i_a1] <= i_wd1;
    end
endmodule // dmau_ram_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// tb_top: random self-checking bench for the data memory address unit
// assumes dmau_core, dmau_ram_model and the bound checker are compiled
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import dmau_pkg::*;
    // ------------------------------------------------------------
    // signals and reference state
    // ------------------------------------------------------------
    logic i_sys_clk = 0, i_rst = 1, i_slen_we = 0, i_req = 0, i_we = 0;
    logic i_fval = 0, i_post_en = 0, i_post_dec = 0, i_rfl, o_ram_fen;
    logic o_ram_we, o_ram_wfl, o_busy, o_elem, o_done, o_tag;
    logic [7:0]  i_slen = 0, i_rd0, i_rd1, o_ram_wd0, o_ram_wd1, o_slen;
    dmau_mode_t  i_mode = DMAU_M_BYTE;
    dmau_fop_t   i_fop = DMAU_F_READ;
    logic [15:0] i_addr = 0, i_wdata = 0, o_ram_a0, o_ram_a1, o_ptr_new;
    logic [15:0] o_rdata;
    logic [1:0]  o_ram_ben;
    int          fails = 0, compares = 0;
    logic [7:0]  bm [0:1279];  // reference bytes
    logic        fl [0:639];   // reference flags
    logic        tg = 0;       // reference tag
    logic [15:0] got [$];      // elements seen
    always #10 i_sys_clk = ~i_sys_clk;
    dmau_core dmau_core_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_slen_we(i_slen_we), .i_slen(i_slen), .i_req(i_req),
        .i_mode(i_mode), .i_we(i_we), .i_fop(i_fop), .i_fval(i_fval),
        .i_addr(i_addr), .i_post_en(i_post_en), .i_post_dec(i_post_dec),
        .i_wdata(i_wdata), .i_rd0(i_rd0), .i_rd1(i_rd1), .i_rfl(i_rfl),
        .o_ram_a0(o_ram_a0), .o_ram_a1(o_ram_a1), .o_ram_ben(o_ram_ben),
        .o_ram_fen(o_ram_fen), .o_ram_we(o_ram_we), .o_ram_wd0(o_ram_wd0),
        .o_ram_wd1(o_ram_wd1), .o_ram_wfl(o_ram_wfl), .o_busy(o_busy),
        .o_elem(o_elem), .o_rdata(o_rdata), .o_done(o_done),
        .o_ptr_new(o_ptr_new), .o_tag(o_tag), .o_slen(o_slen));
    dmau_ram_model dmau_ram_model_i (.i_sys_clk(i_sys_clk), .i_a0(o_ram_a0),
        .i_a1(o_ram_a1), .i_ben(o_ram_ben), .i_fen(o_ram_fen),
        .i_we(o_ram_we), .i_wd0(o_ram_wd0), .i_wd1(o_ram_wd1),
        .i_wfl(o_ram_wfl), .o_rd0(i_rd0), .o_rd1(i_rd1), .o_rfl(i_rfl));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one access: taken at the next edge, elements gathered until done
    task automatic run(dmau_mode_t m, logic w, dmau_fop_t f, logic [15:0] a);
        int k;
        got.delete();
        i_mode = m;
        i_we = w;
        i_fop = f;
        i_addr = a;
        i_req = 1;
        @(posedge i_sys_clk) #1 i_req = 0;
        for (k = 0; k < 300 && !o_done; k++) begin
            if (o_elem) got.push_back(o_rdata);
            @(posedge i_sys_clk) #1;
        end
        if (k == 300) begin
            fails++;
            complete_run();
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int i, j, k, md, n, cnt, st;
        logic [15:0] a, e;
        dmau_fop_t f;
        void'($urandom(32'ha9a1));
        for (i = 0; i < 1280; i++) begin
            bm[i] = $urandom;
            fl[i / 2] = $urandom;
            dmau_ram_model_i.mem[i] = bm[i];
            dmau_ram_model_i.flg[i / 2] = fl[i / 2];
        end
        repeat (12) @(posedge i_sys_clk);
        #1 i_rst = 0;
        check("tag_rst", 16'(o_tag), 16'h0);
        check("slen_rst", 16'(o_slen), 16'(DMAU_SLEN_RST));
        $display("test reset done");
        // flag set, clear, write and read, last index and one beyond
        for (k = 0; k < 4; k++) begin
            a = (k < 2) ? 16'($urandom % 24) : 16'(637 + k);
            for (j = 0; j < 6; j++) begin
                f = j[0] ? DMAU_F_READ : dmau_fop_t'(j / 2 + 1);
                i_fval = $urandom;
                i_post_en = $urandom;
                run(DMAU_M_FLAG, 1'b0, f, a);
                if (a < 640 && f != DMAU_F_READ)
                    fl[a] = (f == DMAU_F_SET) || (f == DMAU_F_WRITE && i_fval);
                if (f == DMAU_F_READ) tg = (a < 640) ? fl[a] : 1'b0;
                check("flag_tag", 16'(o_tag), 16'(tg));
                check("flag_ptr", o_ptr_new, a);
            end
        end
        $display("test flags done");
        // random byte, word and string accesses against the reference
        repeat (80) begin
            md = $urandom % 4;
            a = 16'($urandom % 48);
            n = $urandom % 7;
            i_post_en = $urandom;
            i_post_dec = $urandom;
            i_wdata = $urandom;
            i_slen = 8'(n);
            i_slen_we = 1;
            @(posedge i_sys_clk) #1 i_slen_we = 0;
            check("slen", 16'(o_slen), 16'(n));
            cnt = (md == 1 || md == 3) ? n + 2 : 1;
            st = (md >= 2) ? 2 : 1;
            e = (md >= 2) ? (a & 16'hfffe) : a;
            i_we = (md == 0 || md == 2) && ($urandom % 3 == 0);
            run(dmau_mode_t'(md), i_we, DMAU_F_READ, a);
            if (i_we && md == 0) bm[a] = i_wdata[7:0];
            if (i_we && md == 2) begin
                bm[e] = i_wdata[15:8];
                bm[e + 1] = i_wdata[7:0];
            end
            if (!i_we) begin
                check("count", 16'(got.size()), 16'(cnt));
                for (k = 0; k < cnt && k < got.size(); k++)
                    check("data", got[k], (md >= 2) ?
                        {bm[e + 2 * k], bm[e + 2 * k + 1]} : {8'h00, bm[a + k]});
                tg = fl[(e + st * cnt - 1) / 2];
            end
            check("tag", 16'(o_tag), 16'(tg));
            if (i_post_en)
                check("ptr", o_ptr_new, i_post_dec ?
                    16'(a - st * cnt) : 16'(a + st * cnt));
        end
        $display("test random done");
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
